//--- core/ipsm_core.sv
// What this block does
// - Eleven protocol states, uninitialised through timeout
// - Host requests count as events too
// - Error interrupt split into five flag events
// - Transmit irqs give address or data event
// - State changes only on an event
// - Master request in idle generates start
// - Slave enable from master idle; else error
// - Slave idle: address or receive means match
// - Start wait: start seen runs post-start
// - Address waits accept only their own event among transmit/receive
// - Data sent handled in transmit or arb-lost
// - Receive handled in slave idle, read address wait, receive or arb-lost
// - Stop handled in stop wait, arb-lost
// - Arbitration lost handled in start..receive waits
// - NACK handled from start wait to stop wait
// - Timeout handled start..stop wait; timeout state dead
// - Unassigned events give generic error
// - Channel status idle/finish/nack or communicating
`timescale 1ns/10ps

module ipsm_core
   import ipsm_pkg::*;
(
   input wire logic mclk,
   input wire logic arst_n,
   input wire ipsm_host_s host_req,
   input wire ipsm_irq_s irq,
   output ipsm_state_e state,
   output ipsm_mode_e mode,
   output ipsm_chs_e ch_status,
   output ipsm_act_e act,
   output logic act_vld,
   output logic err,
   output ipsm_ev_e ev_taken
);

   ipsm_regs_s r;
   ipsm_regs_s r_nxt;
   ipsm_ev_e ev;
   logic ev_vld;
   logic tx_is_addr;

   // Transmit irqs mean address done only while an address phase is pending
   always_comb
   begin
      tx_is_addr = (r.state == st_master_slave_idle) || (r.state == st_wr_addr_wait);
   end

   // One event per cycle; simultaneous sources are taken by fixed priority
   // and the lower ones are dropped, so the sources must not overlap
   always_comb
   begin
      ev = ev_none;
      ev_vld = 1'b1;
      if (host_req.init)
      begin
         ev = ev_init_req;
      end
      else if (host_req.slave_en)
      begin
         ev = ev_slave_enable_req;
      end
      else if (host_req.master_start)
      begin
         ev = ev_master_start_req;
      end
      else if (irq.error_event_irq && irq.eflag.start)
      begin
         ev = ev_start_seen;
      end
      else if (irq.error_event_irq && irq.eflag.stop)
      begin
         ev = ev_stop_seen;
      end
      else if (irq.error_event_irq && irq.eflag.arb_lost)
      begin
         ev = ev_arb_lost;
      end
      else if (irq.error_event_irq && irq.eflag.nack)
      begin
         ev = ev_nack_seen;
      end
      else if (irq.error_event_irq && irq.eflag.timeout)
      begin
         ev = ev_bus_timeout;
      end
      else if (irq.tx_end_irq || irq.tx_empty_irq)
      begin
         ev = tx_is_addr ? ev_addr_done : ev_data_sent;
      end
      else if (irq.rx_full_irq)
      begin
         ev = ev_data_received;
      end
      else
      begin
         ev_vld = 1'b0;
      end
   end

   always_comb
   begin
      r_nxt = r;
      r_nxt.act = act_none;
      r_nxt.act_vld = 1'b0;
      r_nxt.err = 1'b0;
      r_nxt.ev = ev_none;
      // Without an event nothing moves
      if (ev_vld)
      begin
         r_nxt.ev = ev;
         r_nxt.act_vld = 1'b1;
         // Error is the default; each legal pair below overrides it
         r_nxt.act = act_none;
         r_nxt.err = 1'b1;
         unique case (ev)
            ev_init_req:
            begin
               if (r.state <= st_wr_addr_wait)
               begin
                  r_nxt.act = act_init;
                  r_nxt.err = 1'b0;
                  r_nxt.state = st_master_idle;
                  r_nxt.mode = mode_none;
                  r_nxt.ch_status = chs_idle;
                  r_nxt.nack_seen = 1'b0;
               end
            end
            ev_slave_enable_req:
            begin
               if (r.state == st_master_idle)
               begin
                  r_nxt.act = act_slave_enable;
                  r_nxt.err = 1'b0;
                  r_nxt.state = st_master_slave_idle;
                  r_nxt.ch_status = chs_idle;
               end
            end
            ev_master_start_req:
            begin
               if ((r.state == st_master_idle) || (r.state == st_master_slave_idle))
               begin
                  r_nxt.act = act_gen_start;
                  r_nxt.err = 1'b0;
                  r_nxt.state = st_start_wait;
                  r_nxt.mode = host_req.master_rx ? mode_m_receive : mode_m_send;
                  r_nxt.nack_seen = 1'b0;
                  r_nxt.ch_status = chs_communication;
               end
            end
            ev_start_seen:
            begin
               if (r.state == st_start_wait)
               begin
                  r_nxt.act = act_after_start;
                  r_nxt.err = 1'b0;
                  r_nxt.state = (r.mode == mode_m_receive) ? st_rd_addr_wait : st_wr_addr_wait;
               end
            end
            ev_addr_done:
            begin
               if (r.state == st_master_slave_idle)
               begin
                  // Slave asked to transmit
                  r_nxt.act = act_slave_match;
                  r_nxt.err = 1'b0;
                  r_nxt.state = st_tx_wait;
                  r_nxt.mode = mode_slave;
                  r_nxt.ch_status = chs_communication;
               end
               else if (r.state == st_wr_addr_wait)
               begin
                  r_nxt.act = act_after_addr;
                  r_nxt.err = 1'b0;
                  r_nxt.state = st_tx_wait;
               end
            end
            ev_data_sent:
            begin
               if (r.state == st_tx_wait)
               begin
                  r_nxt.act = act_send_data;
                  r_nxt.err = 1'b0;
                  r_nxt.state = host_req.last_byte ? st_stop_wait : st_tx_wait;
               end
               else if (r.state == st_arb_lost)
               begin
                  // Stay lost; the winner still clocks bytes through us
                  r_nxt.act = act_send_data;
                  r_nxt.err = 1'b0;
               end
            end
            ev_data_received:
            begin
               if (r.state == st_master_slave_idle)
               begin
                  // Slave being written to
                  r_nxt.act = act_slave_match;
                  r_nxt.err = 1'b0;
                  r_nxt.state = st_rx_wait;
                  r_nxt.mode = mode_slave;
                  r_nxt.ch_status = chs_communication;
               end
               else if (r.state == st_rd_addr_wait)
               begin
                  r_nxt.act = act_after_addr;
                  r_nxt.err = 1'b0;
                  r_nxt.state = st_rx_wait;
               end
               else if (r.state == st_rx_wait)
               begin
                  r_nxt.act = act_recv_data;
                  r_nxt.err = 1'b0;
                  r_nxt.state = host_req.last_byte ? st_stop_wait : st_rx_wait;
               end
               else if (r.state == st_arb_lost)
               begin
                  r_nxt.act = act_recv_data;
                  r_nxt.err = 1'b0;
               end
            end
            ev_stop_seen:
            begin
               if ((r.state == st_stop_wait) || (r.state == st_arb_lost))
               begin
                  r_nxt.act = act_comm_end;
                  r_nxt.err = 1'b0;
                  // Slave enable survives only a slave transfer; a master transfer returns to master idle
                  r_nxt.state = (r.mode == mode_slave) ? st_master_slave_idle : st_master_idle;
                  r_nxt.mode = mode_none;
                  r_nxt.ch_status = r.nack_seen ? chs_nack : chs_finish;
                  r_nxt.nack_seen = 1'b0;
               end
            end
            ev_arb_lost:
            begin
               if ((r.state >= st_start_wait) && (r.state <= st_rx_wait))
               begin
                  r_nxt.act = act_arb_lost;
                  r_nxt.err = 1'b0;
                  r_nxt.state = st_arb_lost;
               end
            end
            ev_nack_seen:
            begin
               if ((r.state >= st_start_wait) && (r.state <= st_stop_wait))
               begin
                  r_nxt.act = act_nack;
                  r_nxt.err = 1'b0;
                  r_nxt.state = st_stop_wait;
                  // Bus stays busy until the stop; the NACK is shown only once it is free
                  r_nxt.nack_seen = 1'b1;
               end
            end
            ev_bus_timeout:
            begin
               if ((r.state >= st_start_wait) && (r.state <= st_stop_wait))
               begin
                  r_nxt.act = act_timeout;
                  r_nxt.err = 1'b0;
                  r_nxt.state = st_timeout;
               end
            end
            default:
            begin
               r_nxt.err = 1'b1;
            end
         endcase
      end
   end

   always_ff @(posedge mclk or negedge arst_n)
   begin
      if (!arst_n)
      begin
         r <= IPSM_REGS_RST;
      end
      else
      begin
         r <= r_nxt;
      end
   end

   assign state = r.state;
   assign mode = r.mode;
   assign ch_status = r.ch_status;
   assign act = r.act;
   assign act_vld = r.act_vld;
   assign err = r.err;
   assign ev_taken = r.ev;

endmodule // ipsm_core

//--- inc/ipsm_pkg.sv
package ipsm_pkg;

   localparam int IPSM_STATE_W = 4;
   localparam int IPSM_EV_W = 4;
   localparam int IPSM_ACT_W = 4;

   typedef enum logic [3:0] {
      st_no_init = 4'h0,
      st_master_idle = 4'h1,
      st_master_slave_idle = 4'h2,
      st_start_wait = 4'h3,
      st_wr_addr_wait = 4'h4,
      st_rd_addr_wait = 4'h5,
      st_tx_wait = 4'h6,
      st_rx_wait = 4'h7,
      st_stop_wait = 4'h8,
      st_arb_lost = 4'h9,
      st_timeout = 4'ha
   } ipsm_state_e;

   typedef enum logic [3:0] {
      ev_init_req = 4'h0,
      ev_slave_enable_req = 4'h1,
      ev_master_start_req = 4'h2,
      ev_start_seen = 4'h3,
      ev_addr_done = 4'h4,
      ev_data_sent = 4'h5,
      ev_data_received = 4'h6,
      ev_stop_seen = 4'h7,
      ev_arb_lost = 4'h8,
      ev_nack_seen = 4'h9,
      ev_bus_timeout = 4'ha,
      ev_none = 4'hf
   } ipsm_ev_e;

   typedef enum logic [3:0] {
      act_init = 4'h0,
      act_gen_start = 4'h1,
      act_after_start = 4'h2,
      act_after_addr = 4'h3,
      act_slave_match = 4'h4,
      act_send_data = 4'h5,
      act_recv_data = 4'h6,
      act_comm_end = 4'h7,
      act_arb_lost = 4'h8,
      act_nack = 4'h9,
      act_slave_enable = 4'ha,
      act_timeout = 4'hb,
      act_none = 4'hf
   } ipsm_act_e;

   typedef enum logic [1:0] {
      mode_none = 2'h0,
      mode_m_send = 2'h1,
      mode_m_receive = 2'h2,
      mode_slave = 2'h3
   } ipsm_mode_e;

   typedef enum logic [2:0] {
      chs_no_init = 3'h0,
      chs_idle = 3'h1,
      chs_finish = 3'h2,
      chs_nack = 3'h3,
      chs_communication = 3'h4
   } ipsm_chs_e;

   typedef struct packed {
      logic init;
      logic slave_en;
      logic master_start;
      logic master_rx;
      logic last_byte;
   } ipsm_host_s;

   typedef struct packed {
      logic start;
      logic stop;
      logic arb_lost;
      logic nack;
      logic timeout;
   } ipsm_eflag_s;

   typedef struct packed {
      logic error_event_irq;
      ipsm_eflag_s eflag;
      logic tx_end_irq;
      logic tx_empty_irq;
      logic rx_full_irq;
   } ipsm_irq_s;

   typedef struct packed {
      ipsm_state_e state;
      ipsm_mode_e mode;
      ipsm_chs_e ch_status;
      ipsm_act_e act;
      logic act_vld;
      logic err;
      logic nack_seen;
      ipsm_ev_e ev;
   } ipsm_regs_s;

   localparam ipsm_regs_s IPSM_REGS_RST = '{
      state: st_no_init,
      mode: mode_none,
      ch_status: chs_no_init,
      act: act_none,
      act_vld: 1'b0,
      err: 1'b0,
      nack_seen: 1'b0,
      ev: ev_none
   };

endpackage

//--- bench/ipsm_irq_model.sv
`timescale 1ns/10ps
module ipsm_irq_model
   import ipsm_pkg::*;
(
   input wire logic [3:0] cmd,
   output ipsm_irq_s irq
);
   always_comb
   begin
      irq = '0;
      // Flags float high outside an error irq, so a decoder that ignores the qualifier is caught
      irq.eflag = 5'h1f;
      case (cmd)
         4'h1, 4'h2, 4'h3, 4'h4, 4'h5:
         begin
            irq.error_event_irq = 1'b1;
            irq.eflag = 5'h10 >> (cmd - 4'h1);
         end
         4'h6: irq.tx_end_irq = 1'b1;
         4'h7: irq.tx_empty_irq = 1'b1;
         4'h8: irq.rx_full_irq = 1'b1;
         default: ;
      endcase
   end
endmodule // ipsm_irq_model

//--- bench/ipsm_core_props.sv
`timescale 1ns/10ps
module ipsm_core_props
   import ipsm_pkg::*;
(
   input wire logic mclk,
   input wire logic arst_n,
   input wire ipsm_host_s host_req,
   input wire ipsm_irq_s irq,
   input wire ipsm_state_e state,
   input wire ipsm_mode_e mode,
   input wire ipsm_chs_e ch_status,
   input wire ipsm_act_e act,
   input wire logic act_vld,
   input wire logic err,
   input wire ipsm_ev_e ev_taken
);
   default clocking cb @(posedge mclk);
   endclocking
   default disable iff (!arst_n);
   logic quiet;
   assign quiet = host_req == '0 && !irq.error_event_irq && !irq.tx_end_irq
      && !irq.tx_empty_irq && !irq.rx_full_irq;
   property p_quiet;
      quiet |=> !act_vld && $stable(state);
   endproperty
   a_quiet: assert property (p_quiet) else $error("state moved without an event");
   property p_err_form;
      err |-> act == act_none && act_vld;
   endproperty
   a_err_form: assert property (p_err_form) else $error("error pulse malformed");
   property p_no_init;
      state == st_no_init && !host_req.init && irq.rx_full_irq |=> err;
   endproperty
   a_no_init: assert property (p_no_init) else $error("event taken before init");
   property p_gen_start;
      state inside {st_master_idle, st_master_slave_idle} && host_req.master_start
         && !host_req.init && !host_req.slave_en |=> act == act_gen_start && state == st_start_wait;
   endproperty
   a_gen_start: assert property (p_gen_start) else $error("no start from idle");
   property p_slave_twice;
      state == st_master_slave_idle && host_req.slave_en && !host_req.init |=> err;
   endproperty
   a_slave_twice: assert property (p_slave_twice) else $error("second slave enable taken");
   property p_start_seen;
      state == st_start_wait && host_req == '0 && irq.error_event_irq && irq.eflag.start
         |=> act == act_after_start;
   endproperty
   a_start_seen: assert property (p_start_seen) else $error("start not handled");
   property p_stop_ok;
      ev_taken == ev_stop_seen && !err |-> $past(state) inside {st_stop_wait, st_arb_lost};
   endproperty
   a_stop_ok: assert property (p_stop_ok) else $error("stop handled in wrong state");
   property p_tmo_dead;
      state == st_timeout |=> state == st_timeout;
   endproperty
   a_tmo_dead: assert property (p_tmo_dead) else $error("timeout state left");
   property p_chs;
      state >= st_start_wait |-> ch_status == chs_communication;
   endproperty
   a_chs: assert property (p_chs) else $error("busy status wrong");
   property p_chs_free;
      state inside {st_master_idle, st_master_slave_idle}
         |-> ch_status inside {chs_idle, chs_finish, chs_nack};
   endproperty
   a_chs_free: assert property (p_chs_free) else $error("free status wrong");
   c_start: cover property (act == act_gen_start);
   c_al: cover property (state == st_arb_lost);
   c_tmo: cover property (state == st_timeout);
   c_nack_end: cover property (ev_taken == ev_stop_seen && ch_status == chs_nack);
endmodule // ipsm_core_props

//--- bench/i2c_protocol_state_machine_tb.sv
`timescale 1ns/10ps
module i2c_protocol_state_machine_tb
   import ipsm_pkg::*;
;
   typedef struct packed {
      logic [4:0] host;
      logic [3:0] cmd;
      ipsm_act_e act;
      ipsm_state_e st;
      logic err;
   } ipsm_row_s;
   logic mclk = 1'b0;
   logic arst_n = 1'b0;
   ipsm_host_s host_req = '0;
   logic [3:0] cmd = 4'h0;
   ipsm_irq_s irq;
   ipsm_state_e state;
   ipsm_mode_e mode;
   ipsm_chs_e ch_status;
   ipsm_act_e act;
   logic act_vld;
   logic err;
   ipsm_ev_e ev_taken;
   int failures = 0;
   int total_checks = 0;
   int cyc = 0;
   // Host codes: 10 init, 08 slave, 04 send, 06 receive, 01 last byte
   ipsm_row_s rows [0:30] = '{
      '{5'h00, 4'h8, act_none, st_no_init, 1'b1}, '{5'h10, 4'h0, act_init, st_master_idle, 1'b0},
      '{5'h04, 4'h0, act_gen_start, st_start_wait, 1'b0},
      '{5'h00, 4'h1, act_after_start, st_wr_addr_wait, 1'b0},
      '{5'h00, 4'h8, act_none, st_wr_addr_wait, 1'b1},
      '{5'h00, 4'h6, act_after_addr, st_tx_wait, 1'b0},
      '{5'h00, 4'h7, act_send_data, st_tx_wait, 1'b0},
      '{5'h01, 4'h7, act_send_data, st_stop_wait, 1'b0},
      '{5'h00, 4'h3, act_none, st_stop_wait, 1'b1},
      '{5'h00, 4'h2, act_comm_end, st_master_idle, 1'b0},
      '{5'h06, 4'h0, act_gen_start, st_start_wait, 1'b0},
      '{5'h00, 4'h1, act_after_start, st_rd_addr_wait, 1'b0},
      '{5'h00, 4'h6, act_none, st_rd_addr_wait, 1'b1},
      '{5'h00, 4'h8, act_after_addr, st_rx_wait, 1'b0},
      '{5'h01, 4'h8, act_recv_data, st_stop_wait, 1'b0},
      '{5'h00, 4'h4, act_nack, st_stop_wait, 1'b0},
      '{5'h00, 4'h2, act_comm_end, st_master_idle, 1'b0},
      '{5'h08, 4'h0, act_slave_enable, st_master_slave_idle, 1'b0},
      '{5'h08, 4'h0, act_none, st_master_slave_idle, 1'b1},
      '{5'h00, 4'h1, act_none, st_master_slave_idle, 1'b1},
      '{5'h00, 4'h6, act_slave_match, st_tx_wait, 1'b0},
      '{5'h00, 4'h2, act_none, st_tx_wait, 1'b1}, '{5'h00, 4'h4, act_nack, st_stop_wait, 1'b0},
      '{5'h00, 4'h2, act_comm_end, st_master_slave_idle, 1'b0},
      '{5'h00, 4'h8, act_slave_match, st_rx_wait, 1'b0},
      '{5'h00, 4'h3, act_arb_lost, st_arb_lost, 1'b0},
      '{5'h00, 4'h8, act_recv_data, st_arb_lost, 1'b0},
      '{5'h00, 4'h7, act_send_data, st_arb_lost, 1'b0},
      '{5'h00, 4'h4, act_none, st_arb_lost, 1'b1}, '{5'h00, 4'h5, act_none, st_arb_lost, 1'b1},
      '{5'h10, 4'h0, act_none, st_arb_lost, 1'b1}};
   always #5 mclk = ~mclk;
   ipsm_irq_model peer (.cmd(cmd), .irq(irq));
   ipsm_core dut (.mclk(mclk), .arst_n(arst_n), .host_req(host_req), .irq(irq),
      .state(state), .mode(mode), .ch_status(ch_status), .act(act), .act_vld(act_vld),
      .err(err), .ev_taken(ev_taken));
   task check(input string what, input logic [3:0] seen, input logic [3:0] exp);
      total_checks++;
      if (seen !== exp)
      begin
         failures++;
         $display("CHECK FAILED %s expected %h seen %h", what, exp, seen);
      end
   endtask
   task final_report;
      $display("checks %0d failures %0d", total_checks, failures);
      if (failures == 0 && total_checks > 0)
         $display("Run complete: PASS");
      else
         $display("Run complete: FAIL");
      $finish;
   endtask
   task apply(input ipsm_row_s r);
      @(negedge mclk);
      host_req = r.host;
      cmd = r.cmd;
      @(negedge mclk);
      host_req = '0;
      cmd = 4'h0;
      check("act", act, r.act);
      check("state", state, r.st);
      check("err", {3'h0, err}, {3'h0, r.err});
      check("act_vld", {3'h0, act_vld}, 4'h1);
   endtask
   always @(posedge mclk)
   begin
      cyc++;
      // Whole run needs well under 300 cycles
      if (cyc == 2000)
      begin
         failures++;
         final_report;
      end
   end
   initial
   begin
      repeat (16) @(posedge mclk);
      @(negedge mclk);
      arst_n = 1'b1;
      check("state", state, st_no_init);
      foreach (rows[i]) apply(rows[i]);
      $display("table test done");
      @(negedge mclk);
      arst_n = 1'b0;
      @(negedge mclk);
      check("state", state, st_no_init);
      check("act_vld", {3'h0, act_vld}, 4'h0);
      arst_n = 1'b1;
      apply('{5'h10, 4'h0, act_init, st_master_idle, 1'b0});
      check("ch_status", {1'b0, ch_status}, {1'b0, chs_idle});
      check("ev_taken", ev_taken, ev_init_req);
      apply('{5'h04, 4'h8, act_gen_start, st_start_wait, 1'b0});
      check("mode", {2'h0, mode}, {2'h0, mode_m_send});
      check("ev_taken", ev_taken, ev_master_start_req);
      apply('{5'h00, 4'h1, act_after_start, st_wr_addr_wait, 1'b0});
      check("ev_taken", ev_taken, ev_start_seen);
      apply('{5'h00, 4'h6, act_after_addr, st_tx_wait, 1'b0});
      check("ev_taken", ev_taken, ev_addr_done);
      apply('{5'h00, 4'h7, act_send_data, st_tx_wait, 1'b0});
      check("ev_taken", ev_taken, ev_data_sent);
      apply('{5'h00, 4'h4, act_nack, st_stop_wait, 1'b0});
      check("ch_status", {1'b0, ch_status}, {1'b0, chs_communication});
      check("ev_taken", ev_taken, ev_nack_seen);
      apply('{5'h00, 4'h2, act_comm_end, st_master_idle, 1'b0});
      check("ch_status", {1'b0, ch_status}, {1'b0, chs_nack});
      check("mode", {2'h0, mode}, {2'h0, mode_none});
      apply('{5'h06, 4'h0, act_gen_start, st_start_wait, 1'b0});
      check("mode", {2'h0, mode}, {2'h0, mode_m_receive});
      apply('{5'h00, 4'h1, act_after_start, st_rd_addr_wait, 1'b0});
      apply('{5'h00, 4'h8, act_after_addr, st_rx_wait, 1'b0});
      apply('{5'h01, 4'h8, act_recv_data, st_stop_wait, 1'b0});
      check("ev_taken", ev_taken, ev_data_received);
      apply('{5'h00, 4'h2, act_comm_end, st_master_idle, 1'b0});
      check("ch_status", {1'b0, ch_status}, {1'b0, chs_finish});
      check("ev_taken", ev_taken, ev_stop_seen);
      apply('{5'h08, 4'h0, act_slave_enable, st_master_slave_idle, 1'b0});
      check("ev_taken", ev_taken, ev_slave_enable_req);
      apply('{5'h04, 4'h0, act_gen_start, st_start_wait, 1'b0});
      apply('{5'h00, 4'h5, act_timeout, st_timeout, 1'b0});
      check("ch_status", {1'b0, ch_status}, {1'b0, chs_communication});
      check("ev_taken", ev_taken, ev_bus_timeout);
      apply('{5'h10, 4'h0, act_none, st_timeout, 1'b1});
      $display("reset and timeout test done");
      final_report;
   end
endmodule // i2c_protocol_state_machine_tb
bind ipsm_core ipsm_core_props u_props (.mclk(mclk), .arst_n(arst_n), .host_req(host_req),
   .irq(irq), .state(state), .mode(mode), .ch_status(ch_status), .act(act),
   .act_vld(act_vld), .err(err), .ev_taken(ev_taken));
